// ===== inc/rsops_pkg.sv
// constants and types shared by the rotate / subtract / special-page datapath
package rsops_pkg;
   // ******************************************************
   // operation codes from the decoder
   // ******************************************************
   typedef enum logic [2:0] {
      OP_NONE         = 3'h0,
      OP_ROT_LEFT     = 3'h1,
      OP_ROT_RIGHT    = 3'h3,
      OP_SUB_REG      = 3'h2,
      OP_SUB_IMM      = 3'h6,
      OP_SPECIAL_READ = 3'h7
   } op_e;

   localparam int          DATA_W       = 8;
   localparam int          SFR_IDX_W    = 4;
   localparam int          REG_ADDR_W   = 6;
   localparam logic [7:0]  WORK_RESET   = 8'h00;
   localparam logic        FLAG_RESET   = 1'b0;
   localparam logic        DEST_WORK    = 1'b0;
   localparam int          CYCLES_PER_OP = 1;
endpackage : rsops_pkg

// ===== inc/alu_if.sv
// interface carrying operands and results between the datapath and its arithmetic unit
interface alu_if;
   logic [7:0] a;
   logic [7:0] b;
   logic       cin;
   logic [7:0] sum;
   logic       cout;
   logic       hcout;

   modport user (output a, output b, output cin, input sum, input cout, input hcout);
   modport unit (input a, input b, input cin, output sum, output cout, output hcout);
endinterface : alu_if

// ===== hdl/sub_borrow_unit.sv
// combinational add-with-inverted-operand unit used for subtract with borrow
module sub_borrow_unit (
   alu_if.unit bus
);
   logic [4:0] low_sum;
   logic [8:0] full_sum;

   // a + ~b + cin: carry out high means no borrow
   always_comb begin
      low_sum   = {1'b0, bus.a[3:0]} + {1'b0, ~bus.b[3:0]} + {4'h0, bus.cin};
      full_sum  = {1'b0, bus.a} + {1'b0, ~bus.b} + {8'h00, bus.cin};
      bus.sum   = full_sum[7:0];
      bus.cout  = full_sum[8];
      bus.hcout = low_sum[4];
   end
endmodule : sub_borrow_unit

// ===== hdl/rotate_subtract_sfr_ops.sv
// execution datapath for rotate, subtract-with-borrow and special-page read
//
// timing in brief: an op is taken on the rising edge that sees op_valid, clk_en and a
// released reset together, and its results show one cycle later, straight from flops.
// done and reg_we are one-cycle pulses; work_reg and the flags stand until the next op.
// clk_en low freezes every datapath flop, pulses included, so a stalled core sees them held.
// limitation: reg_rdata and sfr_rdata must be settled in the cycle the op is presented,
// since the datapath reads them combinationally and keeps no copy of the operands.
module rotate_subtract_sfr_ops (
   input  wire logic                           core_clk,
   input  wire logic                           arst_n,
   input  wire logic                           clk_en,
   input  wire logic                           op_valid,
   input  wire rsops_pkg::op_e                 op_code,
   input  wire logic                           dest_sel,
   input  wire logic [rsops_pkg::REG_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]                     reg_rdata,
   input  wire logic [7:0]                     imm_data,
   input  wire logic [rsops_pkg::SFR_IDX_W-1:0] sfr_idx,
   input  wire logic [7:0]                     sfr_rdata,
   output logic [7:0]                          work_reg,
   output logic                                zero_flag,
   output logic                                half_carry_flag,
   output logic                                carry_flag,
   output logic                                reg_we,
   output logic [rsops_pkg::REG_ADDR_W-1:0]    reg_waddr,
   output logic [7:0]                          reg_wdata,
   output logic [rsops_pkg::SFR_IDX_W-1:0]     sfr_raddr,
   output logic                                done
);
   // ******************************************************
   // reset release
   // ******************************************************
   logic rst_meta_q;
   logic rst_sync_q;

   // two stages so release is clean against core_clk
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // ******************************************************
   // decode and bit-shuffling helpers
   // ******************************************************
   // true for the op whose first operand is the literal, not the register
   function automatic logic uses_immediate(input rsops_pkg::op_e op);
      uses_immediate = (op == rsops_pkg::OP_SUB_IMM);
   endfunction : uses_immediate

   // immediate subtract and special read have no destination bit; they always load work_reg
   function automatic logic lands_in_work(input rsops_pkg::op_e op, input logic dest);
      lands_in_work = uses_immediate(op) || (op == rsops_pkg::OP_SPECIAL_READ) || (dest == rsops_pkg::DEST_WORK);
   endfunction : lands_in_work

   // rotate left through carry, packed as {new carry, result}
   function automatic logic [8:0] rotl_carry(input logic [7:0] value, input logic cin);
      rotl_carry = {value, cin};
   endfunction : rotl_carry

   // rotate right through carry, packed as {result, new carry}
   function automatic logic [8:0] rotr_carry(input logic [7:0] value, input logic cin);
      rotr_carry = {cin, value};
   endfunction : rotr_carry

   // ******************************************************
   // state
   // ******************************************************
   // declared ahead of the adder, which reads work_reg_q and carry_q
   logic [7:0]                       work_reg_q, work_reg_d;
   logic                             zero_q, zero_d;
   logic                             half_q, half_d;
   logic                             carry_q, carry_d;
   logic                             we_q, we_d;
   logic [rsops_pkg::REG_ADDR_W-1:0] waddr_q, waddr_d;
   logic [7:0]                       wdata_q, wdata_d;
   logic [rsops_pkg::SFR_IDX_W-1:0]  sfr_addr_q, sfr_addr_d;
   logic                             done_q, done_d;
   logic [7:0]                       result;

   // ******************************************************
   // arithmetic unit
   // ******************************************************
   // one adder serves both subtracts; only its first operand differs
   alu_if alu ();

   sub_borrow_unit u_sub (
      .bus (alu)
   );

   // register subtract uses the register, immediate subtract the literal
   assign alu.a   = uses_immediate(op_code) ? imm_data : reg_rdata;
   assign alu.b   = work_reg_q;
   assign alu.cin = carry_q;

   // ******************************************************
   // next state
   // ******************************************************
   // every op completes in the cycle it is presented; nothing is pipelined,
   // so back-to-back ops always see the flags the previous op left behind
   always_comb begin
      work_reg_d = work_reg_q;
      zero_d     = zero_q;
      half_d     = half_q;
      carry_d    = carry_q;
      we_d       = 1'b0;
      waddr_d    = waddr_q;
      wdata_d    = wdata_q;
      sfr_addr_d = sfr_idx;
      done_d     = 1'b0;
      result     = 8'h00;
      if (op_valid) begin
         unique case (op_code)
            // rotates touch carry only; zero and half-carry hold
            rsops_pkg::OP_ROT_LEFT: begin
               {carry_d, result} = rotl_carry(reg_rdata, carry_q);
            end
            rsops_pkg::OP_ROT_RIGHT: begin
               {result, carry_d} = rotr_carry(reg_rdata, carry_q);
            end
            // carry out of the adder is the no-borrow sense the flag wants
            rsops_pkg::OP_SUB_REG,
            rsops_pkg::OP_SUB_IMM: begin
               result  = alu.sum;
               zero_d  = (alu.sum == 8'h00);
               half_d  = alu.hcout;
               carry_d = alu.cout;
            end
            // special read leaves every flag alone
            rsops_pkg::OP_SPECIAL_READ: begin
               result = sfr_rdata;
            end
            // no op: only sfr_raddr follows sfr_idx and no pulse is raised
            rsops_pkg::OP_NONE: begin
               result = work_reg_q;
            end
            default: begin
               result = work_reg_q;
            end
         endcase
         if (op_code != rsops_pkg::OP_NONE) begin
            done_d = 1'b1;
            // immediate subtract and special read always land in work_reg
            if (lands_in_work(op_code, dest_sel)) begin
               work_reg_d = result;
            end else begin
               we_d    = 1'b1;
               waddr_d = reg_addr;
               wdata_d = result;
            end
         end
      end
   end

   // ******************************************************
   // registers
   // ******************************************************
   // registers only; clock enable freezes everything.
   // the synchronised reset clears the same flops so the first op after release
   // cannot meet a half-released datapath
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         work_reg_q <= rsops_pkg::WORK_RESET;
         zero_q     <= rsops_pkg::FLAG_RESET;
         half_q     <= rsops_pkg::FLAG_RESET;
         carry_q    <= rsops_pkg::FLAG_RESET;
         we_q       <= 1'b0;
         waddr_q    <= '0;
         wdata_q    <= 8'h00;
         sfr_addr_q <= '0;
         done_q     <= 1'b0;
      end else if (!rst_sync_q) begin
         work_reg_q <= rsops_pkg::WORK_RESET;
         zero_q     <= rsops_pkg::FLAG_RESET;
         half_q     <= rsops_pkg::FLAG_RESET;
         carry_q    <= rsops_pkg::FLAG_RESET;
         we_q       <= 1'b0;
         waddr_q    <= '0;
         wdata_q    <= 8'h00;
         sfr_addr_q <= '0;
         done_q     <= 1'b0;
      end else if (clk_en) begin
         work_reg_q <= work_reg_d;
         zero_q     <= zero_d;
         half_q     <= half_d;
         carry_q    <= carry_d;
         we_q       <= we_d;
         waddr_q    <= waddr_d;
         wdata_q    <= wdata_d;
         sfr_addr_q <= sfr_addr_d;
         done_q     <= done_d;
      end
   end

   // ******************************************************
   // output ports
   // ******************************************************
   // outputs straight from flops, so the register file sees no combinational path
   assign work_reg        = work_reg_q;
   assign zero_flag       = zero_q;
   assign half_carry_flag = half_q;
   assign carry_flag      = carry_q;
   assign reg_we          = we_q;
   assign reg_waddr       = waddr_q;
   assign reg_wdata       = wdata_q;
   assign sfr_raddr       = sfr_addr_q;
   assign done            = done_q;
endmodule : rotate_subtract_sfr_ops

// ===== tb/rsops_props.sv
// concurrent checks on the datapath top ports
module rsops_props (
   input wire logic           core_clk, arst_n, clk_en, op_valid, dest_sel, zero_flag,
   input wire logic           half_carry_flag, carry_flag, reg_we, done,
   input wire rsops_pkg::op_e op_code,
   input wire logic [7:0]     reg_rdata, imm_data, sfr_rdata, work_reg, reg_wdata
);
   logic [1:0] up_q, up_d;
   logic [8:0] sub9, rl9, rr9;
   logic       tk;
   // ops are refused until the reset synchroniser lets go
   always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) up_q <= 2'h0;
      else up_q <= up_d;
   end
   // expected carry and result, packed so $past sees one signal
   assign tk   = clk_en && op_valid && op_code != rsops_pkg::OP_NONE && up_q >= 2'h2;
   assign sub9 = {1'b0, op_code == rsops_pkg::OP_SUB_IMM ? imm_data : reg_rdata} + {1'b0, ~work_reg} + 9'(carry_flag);
   assign rl9  = {reg_rdata, carry_flag};
   assign rr9  = {carry_flag, reg_rdata};
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   sequence s_rl; tk && op_code == rsops_pkg::OP_ROT_LEFT; endsequence
   sequence s_rr; tk && op_code == rsops_pkg::OP_ROT_RIGHT; endsequence
   sequence s_sr; tk && op_code == rsops_pkg::OP_SUB_REG; endsequence
   a_rotl_back: assert property (s_rl ##0 dest_sel |=> reg_we && {carry_flag, reg_wdata} == $past(rl9))
      else $error("rotate left write back wrong");
   a_rotr_work: assert property (s_rr ##0 !dest_sel |=> !reg_we && {work_reg, carry_flag} == $past(rr9))
      else $error("rotate right result wrong");
   a_rotr_back: assert property (s_rr ##0 dest_sel |=> reg_we && {reg_wdata, carry_flag} == $past(rr9))
      else $error("rotate right write back wrong");
   a_rot_flags: assert property ((s_rl or s_rr) |=> done && $stable(zero_flag) && $stable(half_carry_flag))
      else $error("rotate touched flags");
   a_imm_sub: assert property (tk && op_code == rsops_pkg::OP_SUB_IMM |=> {carry_flag, work_reg} == $past(sub9))
      else $error("immediate subtract wrong");
   a_reg_sub: assert property (s_sr ##0 dest_sel |=> reg_we && {carry_flag, reg_wdata} == $past(sub9))
      else $error("register subtract wrong");
   a_zero_sets: assert property (s_sr ##0 sub9 == 9'h100 |=> zero_flag && carry_flag)
      else $error("zero result flags wrong");
   a_sfr_read: assert property (tk && op_code == rsops_pkg::OP_SPECIAL_READ |=> work_reg == $past(sfr_rdata)
      && $stable(carry_flag) && $stable(zero_flag) && $stable(half_carry_flag) && !reg_we)
      else $error("special page read wrong");
endmodule : rsops_props
bind rotate_subtract_sfr_ops rsops_props u_props (.core_clk, .arst_n, .clk_en, .op_valid, .dest_sel, .zero_flag,
   .half_carry_flag, .carry_flag, .reg_we, .done, .op_code, .reg_rdata, .imm_data, .sfr_rdata, .work_reg, .reg_wdata);

// ===== tb/reg_file_model.sv
// register file and special page as the datapath sees them
module reg_file_model (
   input wire logic       core_clk, reg_we,
   input wire logic [5:0] reg_addr, reg_waddr,
   input wire logic [3:0] sfr_idx,
   input wire logic [7:0] reg_wdata,
   output logic [7:0]     reg_rdata, sfr_rdata
);
   logic [7:0] mem [64];
   // upper half gets bit 7 set so left rotates see a carry out
   initial for (int i = 0; i < 64; i++) mem[i] = 8'(i < 32 ? i : i + 128);
   always @(posedge core_clk) if (reg_we) mem[reg_waddr] <= reg_wdata;
   assign reg_rdata = mem[reg_addr];
   assign sfr_rdata = {4'h0, sfr_idx}; // entry n reads back n
endmodule : reg_file_model

// ===== tb/testbench.sv
// self-checking bench for the rotate, subtract and special-page datapath
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic           core_clk, arst_n, clk_en, op_valid, dest_sel, reg_we, done, zero_flag, half_carry_flag;
   logic           carry_flag, z, h, c;
   rsops_pkg::op_e op_code;
   logic [5:0]     reg_addr, reg_waddr;
   logic [3:0]     sfr_idx, sfr_raddr;
   logic [7:0]     reg_rdata, imm_data, sfr_rdata, work_reg, reg_wdata, w;
   int             errors, n_tests, cyc;
   rotate_subtract_sfr_ops dut (.core_clk, .arst_n, .clk_en, .op_valid, .op_code, .dest_sel, .reg_addr, .reg_rdata,
      .imm_data, .sfr_idx, .sfr_rdata, .work_reg, .zero_flag, .half_carry_flag, .carry_flag, .reg_we, .reg_waddr,
      .reg_wdata, .sfr_raddr, .done);
   reg_file_model regs (.core_clk, .reg_we, .reg_addr, .reg_waddr, .sfr_idx, .reg_wdata, .reg_rdata, .sfr_rdata);
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // hang guard, far above the few dozen cycles needed
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 500) begin
         errors++;
         test_done();
      end
   end
   // one op for one edge, then everything it leaves behind
   task automatic exec(input rsops_pkg::op_e op, input logic d, input logic [5:0] a, input logic [7:0] i,
                       input logic [3:0] s, input logic we, input logic [7:0] wd);
      op_code = op;
      dest_sel = d;
      reg_addr = a;
      imm_data = i;
      sfr_idx = s;
      op_valid = 1'b1;
      @(posedge core_clk);
      #1 op_valid = 1'b0;
      n_tests++;
      if (!(done === 1'b1 && work_reg === w && {zero_flag, half_carry_flag, carry_flag} === {z, h, c}
            && reg_we === we && sfr_raddr === s && (we === 1'b0 || {reg_waddr, reg_wdata} === {a, wd}))) begin
         errors++;
         $display("CHECK FAILED %0t op %0d", $time, op);
      end
      @(posedge core_clk);
      #1;
      n_tests++;
      if (done !== 1'b0 || reg_we !== 1'b0) begin
         errors++;
         $display("CHECK FAILED %0t pulse held op %0d", $time, op);
      end
   endtask : exec
   task automatic t_sfr(input logic [3:0] s);
      w = {4'h0, s};
      exec(rsops_pkg::OP_SPECIAL_READ, 1'b1, 6'h00, 8'h00, s, 1'b0, 8'h00);
   endtask : t_sfr
   task automatic t_rot(input logic left, input logic d, input logic [5:0] a, input logic [7:0] v);
      logic [7:0] s;
      if (left) {c, s} = {v, c};
      else {s, c} = {c, v};
      if (!d) w = s;
      exec(left ? rsops_pkg::OP_ROT_LEFT : rsops_pkg::OP_ROT_RIGHT, d, a, 8'h00, 4'h0, d, s);
   endtask : t_rot
   // v is the register value, or the immediate when imm is set
   task automatic t_sub(input logic imm, input logic d, input logic [5:0] a, input logic [7:0] v);
      logic [7:0] s;
      logic [4:0] lo;
      lo = {1'b0, v[3:0]} + {1'b0, ~w[3:0]} + 5'(c);
      {c, s} = {1'b0, v} + {1'b0, ~w} + 9'(c);
      h = lo[4];
      z = (s == 8'h00);
      if (imm || !d) w = s;
      exec(imm ? rsops_pkg::OP_SUB_IMM : rsops_pkg::OP_SUB_REG, d, a, v, 4'h0, !imm && d, s);
   endtask : t_sub
   task automatic test_done;
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   initial begin
      {arst_n, clk_en, op_valid, dest_sel, z, h, c} = 7'h20;
      {op_code, reg_addr, imm_data, sfr_idx, w} = '0;
      repeat (4) @(posedge core_clk);
      #1 arst_n = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      t_sfr(4'hf);
      t_sfr(4'h6);
      t_rot(1'b1, 1'b1, 6'h25, 8'ha5);
      t_rot(1'b0, 1'b1, 6'h25, 8'h4a);
      t_rot(1'b0, 1'b0, 6'h03, 8'h03);
      t_rot(1'b1, 1'b0, 6'h21, 8'ha1);
      t_rot(1'b0, 1'b0, 6'h02, 8'h02);
      t_sfr(4'h5);
      t_sub(1'b0, 1'b1, 6'h06, 8'h06);
      t_sfr(4'h6);
      t_sub(1'b1, 1'b0, 6'h00, 8'h05);
      t_sfr(4'h6);
      t_sub(1'b1, 1'b0, 6'h00, 8'h05);
      t_sub(1'b0, 1'b0, 6'h06, 8'h00);
      test_done();
   end
endmodule : testbench
